// ---- logic/cig_intr_gen.sv ----
// Function
// - Three interrupt modes (pin, single, multiple message), one selected at a time; MSI-X raises none.
// - Admin completion interrupts bypass coalescing delay.
// - Accept entry threshold hint, one value shared by all vectors.
// - Accept maximum delay hint, loosely honoured.
// - Coalescing settings readable and writable.
// - Mode chosen from enable bits and field.
// - Hidden per-vector status drives wire/messages.
// - Status set: pending, enabled, unmasked.
// - Mask acts before message logic.
// - Pin mode: line low while status0 set.
// - Message on rise or unmask while set.
// - Partial clear: wire stays, new message.
// - All clear: wire released, no message.
// - Mask set and clear registers per bit.
// - All acknowledged entries drop the vector.
// - One vector in pin/single, up to 32.
`timescale 1ns/1ps
module cig_intr_gen #(
  parameter int NV = cig_pkg::NUM_VEC,
  parameter int TICK_CYC = cig_pkg::TIME_UNIT_CYC
) (
  input wire logic ref_clk, // 50 MHz clock
  input wire logic nrst, // Async reset, low
  input wire logic [cig_pkg::ADDR_W-1:0] addr, // Register address
  input wire logic [cig_pkg::DATA_W-1:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [cig_pkg::DATA_W-1:0] rdata, // Read data, next cycle
  input wire cig_pkg::cig_cfg_s cfg, // MSI capability state
  input wire logic [NV-1:0] cq_pending, // Unacked entries per vector
  input wire logic [NV-1:0] cq_ien, // Queue has interrupts on
  input wire logic [NV-1:0] cq_post, // Entry posted per vector
  input wire logic admin_pending, // Admin queue unacked
  input wire logic msi_ack, // Message accepted
  output cig_pkg::cig_msg_s msg, // Message request
  output logic intx_n, // Legacy line, low active
  output logic irq // Local interrupt
);

  localparam int TICK_W = $clog2(TICK_CYC + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

  logic [NV-1:0] vector_mask_bits;
  logic [NV-1:0] vector_pending_status;
  logic [NV-1:0] next_status;
  logic [NV-1:0] msg_req;
  logic [NV-1:0] next_req;
  logic [NV-1:0] served;
  logic [NV-1:0] raw;
  logic [NV-1:0] post_map;
  logic [NV-1:0] ready;
  logic [NV-1:0] rise;
  logic [NV-1:0] fell;
  logic [NV-1:0] in_range;
  logic [cig_pkg::COAL_W-1:0] coal_thr;
  logic [cig_pkg::COAL_W-1:0] coal_tim;
  logic [cig_pkg::EV_W-1:0] evt;
  logic [cig_pkg::EV_W-1:0] evt_en;
  logic [cig_pkg::EV_W-1:0] evt_set;
  logic [TICK_W-1:0] tick_cnt;
  logic tick;
  logic pick_valid;
  logic [cig_pkg::VEC_W-1:0] pick_idx;
  logic bad_q;
  logic partial;
  logic launch;
  cig_pkg::cig_mode_e mode;
  cig_pkg::cig_mode_e mode_q;
  cig_pkg::cig_msg_state_e state;

  assign mode = cig_pkg::decode_mode(cfg);

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_q <= cig_pkg::MODE_PIN;
      bad_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode;
      bad_q <= (mode == cig_pkg::MODE_BAD);
    end
  end

  // Coalescing time base
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      tick_cnt <= '0;
    else if (tick_cnt == TICK_LAST)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + 1'b1;
  end

  assign tick = (tick_cnt == TICK_LAST);

  // Vectors allowed by the enabled-vectors field
  always_comb
  begin
    in_range = '0;
    for (int i = 0; i < NV; i++)
      in_range[i] = (i < (1 << cfg.mme));
  end

  always_comb
  begin
    raw = '0;
    post_map = '0;
    case (mode_q)
      cig_pkg::MODE_PIN, cig_pkg::MODE_SMSI:
      begin
        raw[0] = |(cq_pending & cq_ien) | admin_pending;
        post_map[0] = |(cq_post & cq_ien);
      end
      cig_pkg::MODE_MMSI:
      begin
        raw = cq_pending & cq_ien & in_range;
        raw[0] = raw[0] | admin_pending;
        post_map = cq_post & cq_ien & in_range;
      end
      default:
      begin
        raw = '0;
        post_map = '0;
      end
    endcase
  end

  genvar gv;
  generate
    for (gv = 0; gv < NV; gv++)
    begin : g_coal
      cig_coal #(
        .CNT_W(cig_pkg::COAL_W)
      ) u_coal (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pending(raw[gv]),
        .post(post_map[gv]),
        .bypass((gv == 0) ? admin_pending : 1'b0),
        .thr(coal_thr),
        .tim(coal_tim),
        .tick(tick),
        .ready(ready[gv])
      );
    end
  endgenerate

  // status needs pending, enable, no mask
  assign next_status = raw & ready & ~vector_mask_bits;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      vector_pending_status <= '0;
    else
      vector_pending_status <= next_status;
  end

  assign rise = next_status & ~vector_pending_status;
  assign fell = vector_pending_status & ~next_status;
  assign partial = (|fell) && (|next_status);

  cig_pick #(
    .N(NV),
    .W(cig_pkg::VEC_W)
  ) u_pick (
    .req(msg_req),
    .valid(pick_valid),
    .idx(pick_idx)
  );

  assign launch = (state == cig_pkg::MSG_IDLE) && pick_valid && cig_pkg::is_msi(mode_q);

  always_comb
  begin
    served = '0;
    if (launch)
      served[pick_idx] = 1'b1;
  end

  // rise or unmask queues a message
  always_comb
  begin
    next_req = '0;
    if (cig_pkg::is_msi(mode_q))
    begin
      next_req = (msg_req & ~served & next_status) | rise;
      if (partial)
        next_req = next_req | next_status;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      msg_req <= '0;
    else
      msg_req <= next_req;
  end

  // Message handshake
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= cig_pkg::MSG_IDLE;
      msg <= '0;
    end
    else
    begin
      case (state)
        cig_pkg::MSG_IDLE:
        begin
          if (launch)
          begin
            msg.valid <= 1'b1;
            msg.vector <= pick_idx;
            state <= cig_pkg::MSG_WAIT;
          end
        end
        cig_pkg::MSG_WAIT:
        begin
          if (msi_ack)
          begin
            msg.valid <= 1'b0;
            state <= cig_pkg::MSG_IDLE;
          end
        end
        default:
        begin
          msg <= '0;
          state <= cig_pkg::MSG_IDLE;
        end
      endcase
    end
  end

  // level wire from status bit 0
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      intx_n <= 1'b1;
    else
      intx_n <= !((mode_q == cig_pkg::MODE_PIN) && vector_pending_status[0]);
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      vector_mask_bits <= cig_pkg::MASK_RST;
    else if (wr && addr == cig_pkg::OFF_MASK_SET)
      vector_mask_bits <= vector_mask_bits | wdata[NV-1:0];
    else if (wr && addr == cig_pkg::OFF_MASK_CLR)
      vector_mask_bits <= vector_mask_bits & ~wdata[NV-1:0];
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      coal_thr <= cig_pkg::COAL_RST;
      coal_tim <= cig_pkg::COAL_RST;
    end
    else if (wr && addr == cig_pkg::OFF_COAL)
    begin
      coal_thr <= wdata[cig_pkg::COAL_THR_LSB +: cig_pkg::COAL_W];
      coal_tim <= wdata[cig_pkg::COAL_TIM_LSB +: cig_pkg::COAL_W];
    end
  end

  // Local events
  always_comb
  begin
    evt_set = '0;
    evt_set[cig_pkg::EV_MSG] = (state == cig_pkg::MSG_WAIT) && msi_ack;
    evt_set[cig_pkg::EV_WIRE] = intx_n && (mode_q == cig_pkg::MODE_PIN) && vector_pending_status[0];
    evt_set[cig_pkg::EV_CFG] = (mode == cig_pkg::MODE_BAD) && !bad_q;
  end

  // Set wins over clear
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      evt <= cig_pkg::EVT_RST;
    else if (wr && addr == cig_pkg::OFF_EVT_CLR)
      evt <= (evt & ~wdata[cig_pkg::EV_W-1:0]) | evt_set;
    else
      evt <= evt | evt_set;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      evt_en <= cig_pkg::EVT_RST;
    else if (wr && addr == cig_pkg::OFF_EVT_EN)
      evt_en <= wdata[cig_pkg::EV_W-1:0];
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= |(evt & evt_en);
  end

  // Register read port
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      rdata <= '0;
    else if (rd)
    begin
      rdata <= '0;
      case (addr)
        cig_pkg::OFF_MASK_SET, cig_pkg::OFF_MASK_CLR:
          rdata[NV-1:0] <= vector_mask_bits;
        cig_pkg::OFF_COAL:
        begin
          rdata[cig_pkg::COAL_THR_LSB +: cig_pkg::COAL_W] <= coal_thr;
          rdata[cig_pkg::COAL_TIM_LSB +: cig_pkg::COAL_W] <= coal_tim;
        end
        cig_pkg::OFF_EVT_STAT:
          rdata[cig_pkg::EV_W-1:0] <= evt;
        cig_pkg::OFF_EVT_EN:
          rdata[cig_pkg::EV_W-1:0] <= evt_en;
        cig_pkg::OFF_STATE:
        begin
          rdata[cig_pkg::ST_INTX_N] <= intx_n;
          rdata[cig_pkg::ST_MSG_BUSY] <= msg.valid;
          rdata[cig_pkg::ST_MODE_LSB +: 3] <= mode_q;
        end
        default:
          rdata <= '0;
      endcase
    end
  end

endmodule : cig_intr_gen

// ---- logic/cig_pkg.sv ----
package cig_pkg;

  localparam int NUM_VEC = 32;
  localparam int VEC_W = 5;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MME_W = 3;

  localparam logic [ADDR_W-1:0] OFF_MASK_SET = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_MASK_CLR = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_COAL = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_EVT_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_EVT_CLR = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_EVT_EN = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_STATE = 8'h24;

  localparam int COAL_THR_LSB = 0;
  localparam int COAL_TIM_LSB = 8;
  localparam int COAL_W = 8;

  localparam int EV_MSG = 0;
  localparam int EV_WIRE = 1;
  localparam int EV_CFG = 2;
  localparam int EV_W = 3;

  localparam int ST_INTX_N = 0;
  localparam int ST_MSG_BUSY = 1;
  localparam int ST_MODE_LSB = 4;

  localparam logic [NUM_VEC-1:0] MASK_RST = 32'h0;
  localparam logic [COAL_W-1:0] COAL_RST = 8'h0;
  localparam logic [EV_W-1:0] EVT_RST = 3'h0;
  localparam logic [MME_W-1:0] MME_MAX = 3'h5;

  localparam int CLK_PERIOD_NS = 20;
  localparam int TIME_UNIT_NS = 100000;
  localparam int TIME_UNIT_CYC = TIME_UNIT_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {MODE_PIN, MODE_SMSI, MODE_MMSI, MODE_MSIX, MODE_BAD} cig_mode_e;
  typedef enum logic [0:0] {MSG_IDLE, MSG_WAIT} cig_msg_state_e;

  typedef struct packed {
    logic msie;
    logic [MME_W-1:0] mme;
    logic msix;
  } cig_cfg_s;

  typedef struct packed {
    logic valid;
    logic [VEC_W-1:0] vector;
  } cig_msg_s;

  function automatic cig_mode_e decode_mode(input cig_cfg_s c);
    cig_mode_e m;
    if (!c.msie && !c.msix)
      m = MODE_PIN;
    else if (c.msie && c.msix)
      m = MODE_BAD;
    else if (c.msix)
      m = MODE_MSIX;
    else if (c.mme == 3'h0)
      m = MODE_SMSI;
    else if (c.mme <= MME_MAX)
      m = MODE_MMSI;
    else
      m = MODE_BAD;
    return m;
  endfunction : decode_mode

  function automatic logic is_msi(input cig_mode_e m);
    return (m == MODE_SMSI) || (m == MODE_MMSI);
  endfunction : is_msi

endpackage : cig_pkg

// ---- logic/cig_coal.sv ----
`timescale 1ns/1ps
module cig_coal #(
  parameter int CNT_W = 8
) (
  input wire logic ref_clk, // Clock
  input wire logic nrst, // Async reset, low
  input wire logic pending, // Vector has unacked entries
  input wire logic post, // Entry posted this cycle
  input wire logic bypass, // Raise without delay
  input wire logic [CNT_W-1:0] thr, // Entry threshold hint
  input wire logic [CNT_W-1:0] tim, // Time hint in ticks
  input wire logic tick, // Time unit strobe
  output logic ready // Vector may interrupt
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] age;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt <= '0;
      age <= '0;
    end
    else if (!pending)
    begin
      cnt <= '0;
      age <= '0;
    end
    else
    begin
      if (post && cnt != '1)
        cnt <= cnt + 1'b1;
      if (tick && age != '1)
        age <= age + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      ready <= 1'b0;
    else if (!pending)
      ready <= 1'b0;
    else
      ready <= ready || bypass || (thr == '0 && tim == '0) || (thr != '0 && cnt >= thr)
               || (tim != '0 && age >= tim);
  end

endmodule : cig_coal

// ---- logic/cig_pick.sv ----
`timescale 1ns/1ps
module cig_pick #(
  parameter int N = 32,
  parameter int W = 5
) (
  input wire logic [N-1:0] req, // Request bits
  output logic valid, // Any request
  output logic [W-1:0] idx // Lowest request
);

  always_comb
  begin
    valid = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        valid = 1'b1;
        idx = W'(i);
      end
    end
  end

endmodule : cig_pick

// ---- tb/cig_intr_gen_asserts.sv ----
`timescale 1ns/1ps
module cig_intr_gen_asserts #(
  parameter int NV = cig_pkg::NUM_VEC
) (
  input wire logic ref_clk, // Clock
  input wire logic nrst, // Reset, low
  input wire logic [cig_pkg::ADDR_W-1:0] addr, // Address
  input wire logic [cig_pkg::DATA_W-1:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [cig_pkg::DATA_W-1:0] rdata, // Read data
  input wire cig_pkg::cig_cfg_s cfg, // Mode state
  input wire logic [NV-1:0] cq_pending, // Unacked
  input wire logic [NV-1:0] cq_ien, // Queue enables
  input wire logic admin_pending, // Admin unacked
  input wire logic msi_ack, // Accepted
  input wire cig_pkg::cig_msg_s msg, // Message
  input wire logic intx_n // Legacy line
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [NV-1:0] mask_m;
  logic coal0;
  wire pin = !cfg.msie && !cfg.msix;
  wire pend0 = (|(cq_pending & cq_ien)) || admin_pending;
  // Mirror of the mask and coalescing writes
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      mask_m <= '0;
    else if (wr && addr == cig_pkg::OFF_MASK_SET)
      mask_m <= mask_m | wdata[NV-1:0];
    else if (wr && addr == cig_pkg::OFF_MASK_CLR)
      mask_m <= mask_m & ~wdata[NV-1:0];
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      coal0 <= 1'b1;
    else if (wr && addr == cig_pkg::OFF_COAL)
      coal0 <= wdata[15:0] == 16'h0000;
  wire_set_a:
    assert property ($rose(pend0) ##0 (pend0 && pin && coal0 && !mask_m[0])[*3] |=> !intx_n)
    else $error("line not driven");
  wire_clr_a:
    assert property ((pin && !pend0)[*3] |=> intx_n)
    else $error("line not released");
  mask_wire_a:
    assert property ((pin && mask_m[0])[*3] |-> intx_n)
    else $error("masked line driven");
  msg_hold_a:
    assert property (msg.valid && !msi_ack |=> msg.valid && $stable(msg.vector))
    else $error("message dropped");
  msg_drop_a:
    assert property (msg.valid && msi_ack |=> !msg.valid)
    else $error("message kept after ack");
  msg_mode_a:
    assert property ($rose(msg.valid) |-> cfg.msie && !cfg.msix)
    else $error("message in wrong mode");
  msg_mask_a:
    assert property ($rose(msg.valid) |-> !mask_m[msg.vector])
    else $error("message on masked vector");
  mask_read_a:
    assert property (rd && (addr == cig_pkg::OFF_MASK_SET || addr == cig_pkg::OFF_MASK_CLR)
      |=> rdata[NV-1:0] == mask_m)
    else $error("mask readback wrong");
  zero_read_a:
    assert property (rd && addr == cig_pkg::OFF_EVT_CLR |=> rdata == '0)
    else $error("clear register readable");
  cover property (msg.valid && msi_ack);
  cover property ($fell(intx_n));
  cover property (wr && addr == cig_pkg::OFF_MASK_CLR);
endmodule : cig_intr_gen_asserts

bind cig_intr_gen cig_intr_gen_asserts #(.NV(NV)) u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .cfg(cfg), .cq_pending(cq_pending), .cq_ien(cq_ien),
  .admin_pending(admin_pending), .msi_ack(msi_ack), .msg(msg), .intx_n(intx_n)
);

// ---- tb/cig_host_model.sv ----
`timescale 1ns/1ps
module cig_host_model (
  input wire logic ref_clk, // Clock
  input wire logic nrst, // Reset, low
  input wire cig_pkg::cig_msg_s msg, // Message request
  input wire logic slow, // Late acceptance
  output logic msi_ack, // Accepted
  output logic [7:0] n_msg, // Messages taken
  output logic [4:0] last_vec // Last vector
);
  logic [3:0] dly;
  // One ack pulse per message, after a chosen delay
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      msi_ack <= 1'b0;
      dly <= 4'h0;
      n_msg <= 8'h00;
      last_vec <= 5'h00;
    end
    else if (msi_ack)
    begin
      msi_ack <= 1'b0;
      dly <= 4'h0;
    end
    else if (msg.valid && dly == (slow ? 4'h6 : 4'h0))
    begin
      msi_ack <= 1'b1;
      n_msg <= n_msg + 8'h01;
      last_vec <= msg.vector;
    end
    else if (msg.valid)
      dly <= dly + 4'h1;
endmodule : cig_host_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic ref_clk, nrst, wr, rd, admin_pending, slow, msi_ack, intx_n, irq;
  logic [7:0] addr, n_msg;
  logic [31:0] wdata, rdata, cq_pending, cq_ien, cq_post, rv;
  logic [4:0] last_vec;
  cig_pkg::cig_cfg_s cfg;
  cig_pkg::cig_msg_s msg;
  int failures, n_compared;
  cig_intr_gen #(.TICK_CYC(4)) dut (.ref_clk(ref_clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cfg(cfg), .cq_pending(cq_pending),
    .cq_ien(cq_ien), .cq_post(cq_post), .admin_pending(admin_pending), .msi_ack(msi_ack),
    .msg(msg), .intx_n(intx_n), .irq(irq));
  cig_host_model host (.ref_clk(ref_clk), .nrst(nrst), .msg(msg), .slow(slow),
    .msi_ack(msi_ack), .n_msg(n_msg), .last_vec(last_vec));
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want)
    begin
      failures++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask : rreg
  // New entries raise pending and pulse the post strobe
  task automatic pend(input logic [31:0] p);
    @(posedge ref_clk);
    cq_post <= p & ~cq_pending;
    cq_pending <= p;
    @(posedge ref_clk);
    cq_post <= 32'h0;
  endtask : pend
  task automatic wait_msg(input logic [7:0] n);
    repeat (60) if (n_msg !== n) cyc(1);
    #1;
    check(n_msg, n);
  endtask : wait_msg
  task automatic t_pin;
    rreg(8'h40);
    check(rv, 32'h0);
    rreg(cig_pkg::OFF_MASK_SET);
    check(rv, 32'h0);
    pend(32'h20);
    cyc(1);
    check(intx_n, 1'b1);
    cyc(1);
    check(intx_n, 1'b0);
    pend(32'h80);
    cyc(4);
    check(intx_n, 1'b0);
    pend(32'h0);
    cyc(0);
    check(intx_n, 1'b0);
    cyc(1);
    check(intx_n, 1'b1);
    cq_ien <= 32'hFFFF_FF7F;
    pend(32'h80);
    cyc(6);
    check(intx_n, 1'b1);
    pend(32'h0);
    cq_ien <= 32'hFFFF_FFFF;
  endtask : t_pin
  task automatic t_mask;
    wreg(cig_pkg::OFF_MASK_SET, 32'h1);
    rreg(cig_pkg::OFF_MASK_CLR);
    check(rv, 32'h1);
    pend(32'h2);
    cyc(6);
    check(intx_n, 1'b1);
    wreg(cig_pkg::OFF_MASK_CLR, 32'h1);
    cyc(4);
    check(intx_n, 1'b0);
    pend(32'h0);
    cyc(4);
  endtask : t_mask
  task automatic t_coal;
    wreg(cig_pkg::OFF_COAL, 32'h0000_0002);
    pend(32'h4);
    cyc(6);
    check(intx_n, 1'b1);
    pend(32'h6);
    cyc(3);
    check(intx_n, 1'b0);
    pend(32'h0);
    cyc(4);
    wreg(cig_pkg::OFF_COAL, 32'h0000_02FF);
    rreg(cig_pkg::OFF_COAL);
    check(rv, 32'h0000_02FF);
    pend(32'h4);
    cyc(2);
    check(intx_n, 1'b1);
    repeat (30) if (intx_n !== 1'b0) cyc(1);
    check(intx_n, 1'b0);
    pend(32'h0);
    cyc(4);
    admin_pending <= 1'b1;
    cyc(3);
    check(intx_n, 1'b0);
    admin_pending <= 1'b0;
    wreg(cig_pkg::OFF_COAL, 32'h0);
    cyc(4);
  endtask : t_coal
  task automatic t_msi;
    cfg <= 5'b1_010_0;
    pend(32'h8);
    wait_msg(8'h01);
    check(last_vec, 5'h03);
    check(intx_n, 1'b1);
    pend(32'hA);
    wait_msg(8'h02);
    check(last_vec, 5'h01);
    pend(32'h8);
    wait_msg(8'h03);
    check(last_vec, 5'h03);
    slow <= 1'b1;
    wreg(cig_pkg::OFF_MASK_SET, 32'h8);
    pend(32'h0);
    wreg(cig_pkg::OFF_MASK_CLR, 32'h8);
    cyc(12);
    check(n_msg, 8'h03);
    wreg(cig_pkg::OFF_MASK_SET, 32'h8);
    pend(32'h8);
    cyc(10);
    check(n_msg, 8'h03);
    wreg(cig_pkg::OFF_MASK_CLR, 32'h8);
    wait_msg(8'h04);
    check(last_vec, 5'h03);
    pend(32'h0);
    slow <= 1'b0;
    cfg <= 5'b1_000_0;
    pend(32'h10);
    wait_msg(8'h05);
    check(last_vec, 5'h00);
  endtask : t_msi
  task automatic t_evt;
    wreg(cig_pkg::OFF_EVT_EN, 32'h1);
    pend(32'h0);
    pend(32'h1);
    wait_msg(8'h06);
    cyc(3);
    check(irq, 1'b1);
    rreg(cig_pkg::OFF_EVT_STAT);
    check(rv[0], 1'b1);
    wreg(cig_pkg::OFF_EVT_CLR, 32'h1);
    cyc(2);
    check(irq, 1'b0);
    wreg(cig_pkg::OFF_EVT_EN, 32'h0);
    pend(32'h0);
    pend(32'h1);
    wait_msg(8'h07);
    cyc(3);
    check(irq, 1'b0);
    pend(32'h0);
    cyc(8);
    cfg <= 5'b0_000_1;
    pend(32'h1);
    cyc(10);
    check(intx_n, 1'b1);
    check(n_msg, 8'h07);
    pend(32'h0);
  endtask : t_evt
  // Bad mode, state readback, then a mid-run reset
  task automatic t_reset;
    cfg <= 5'b1_000_1;
    wreg(cig_pkg::OFF_MASK_SET, 32'h5);
    rreg(cig_pkg::OFF_EVT_STAT);
    check(rv[2], 1'b1);
    rreg(cig_pkg::OFF_STATE);
    check(rv, 32'h0000_0041);
    rreg(cig_pkg::OFF_MASK_SET);
    check(rv, 32'h0000_0005);
    @(posedge ref_clk);
    nrst <= 1'b0;
    cyc(2);
    check(rdata, 32'h0);
    check(irq, 1'b0);
    check(intx_n, 1'b1);
    @(posedge ref_clk);
    nrst <= 1'b1;
    rreg(cig_pkg::OFF_MASK_CLR);
    check(rv, 32'h0);
  endtask : t_reset
  task automatic stop_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  initial
  begin
    #200us;
    failures++;
    stop_test;
  end
  initial
  begin
    nrst = 1'b0;
    {wr, rd, admin_pending, slow} = 4'h0;
    addr = 8'h00;
    wdata = 32'h0;
    cq_pending = 32'h0;
    cq_post = 32'h0;
    cq_ien = 32'hFFFF_FFFF;
    cfg = 5'b0_000_0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    cyc(1);
    check(intx_n, 1'b1);
    check(msg.valid, 1'b0);
    t_pin;
    t_mask;
    t_coal;
    t_msi;
    t_evt;
    t_reset;
    stop_test;
  end
endmodule : testbench
